/* File: design/aotb_ctrl.sv */
`timescale 1ns/100ps
module aotb_ctrl #(
    parameter int  MIN_OFF_CYC = aotb_pkg::MIN_OFF_CYC,
    parameter int  DEAD_CYC    = aotb_pkg::DEAD_CYC,
    parameter int  SS_STEP_CYC = aotb_pkg::SS_STEP_CYC,
    parameter bit  LIGHT_LOAD  = 1'b1
) (
    input  wire logic                         CLK,
    input  wire logic                         SRST,
    input  wire logic                         CE,
    input  wire logic                         ENABLE,
    input  wire logic                         FB_BELOW_REF,
    input  wire logic                         ZERO_CROSS_DETECT,
    input  wire logic [aotb_pkg::TON_W-1:0]   TON_CYCLES,
    output aotb_pkg::aotb_gate_t              GATE,
    output logic                              BIAS_RESTORED,
    output aotb_pkg::aotb_status_t            STATUS
);
    // ************************************************************
    // Input synchronisation
    // ************************************************************
    logic [2:0] pins_s;
    logic       en_s;
    logic       fb_low_s;
    logic       zc_s;

    aotb_sync #(.W(3)) u_sync (
        .clk (CLK),
        .ce  (CE),
        .d   ({ENABLE, FB_BELOW_REF, ZERO_CROSS_DETECT}),
        .q   (pins_s)
    );
    assign en_s     = pins_s[2];
    assign fb_low_s = pins_s[1];
    assign zc_s     = pins_s[0];

    // ************************************************************
    // Soft-start
    // ************************************************************
    logic [aotb_pkg::CODE_W-1:0] ref_code;
    logic                        ss_done;

    aotb_softstart #(.STEP_CYC(SS_STEP_CYC), .STEPS(aotb_pkg::SS_STEPS)) u_ss (
        .clk      (CLK),
        .srst     (SRST),
        .ce       (CE),
        .en       (en_s),
        .ref_code (ref_code),
        .done     (ss_done)
    );

    // ************************************************************
    // Switching state machine
    // ************************************************************
    aotb_pkg::aotb_state_t       state_reg;
    aotb_pkg::aotb_state_t       state_next;
    logic [aotb_pkg::CNT_W-1:0]  cnt_reg;
    logic [aotb_pkg::CNT_W-1:0]  cnt_next;
    logic                        wake_bias_reg;

    function automatic logic [aotb_pkg::CNT_W-1:0] load_cnt(input int cycles);
        load_cnt = (cycles > 1) ? aotb_pkg::CNT_W'(cycles - 1) : '0;
    endfunction : load_cnt

    // Next state and interval counter
    always_comb begin
        state_next = state_reg;
        cnt_next   = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        case (state_reg)
            aotb_pkg::ST_IDLE: begin
                if (fb_low_s) begin
                    state_next = aotb_pkg::ST_DEAD_H;
                    cnt_next   = load_cnt(DEAD_CYC);
                end
            end
            aotb_pkg::ST_DEAD_H: begin
                if (cnt_reg == '0) begin
                    state_next = aotb_pkg::ST_ON;
                    cnt_next   = (TON_CYCLES > 1) ? aotb_pkg::CNT_W'(TON_CYCLES - 1'b1) : '0;
                end
            end
            aotb_pkg::ST_ON: begin
                if (cnt_reg == '0) begin
                    state_next = aotb_pkg::ST_DEAD_L;
                    cnt_next   = load_cnt(DEAD_CYC);
                end
            end
            aotb_pkg::ST_DEAD_L: begin
                if (cnt_reg == '0) begin
                    state_next = aotb_pkg::ST_OFF;
                    cnt_next   = load_cnt(MIN_OFF_CYC - DEAD_CYC);
                end
            end
            aotb_pkg::ST_OFF: begin
                if (fb_low_s && cnt_reg == '0) begin
                    state_next = aotb_pkg::ST_DEAD_H;
                    cnt_next   = load_cnt(DEAD_CYC);
                end else if (LIGHT_LOAD && zc_s && !fb_low_s) begin
                    state_next = aotb_pkg::ST_DCM;
                end
            end
            aotb_pkg::ST_DCM: begin
                if (fb_low_s && cnt_reg == '0) begin
                    state_next = aotb_pkg::ST_WAKE;
                    cnt_next   = load_cnt(DEAD_CYC);
                end
            end
            aotb_pkg::ST_WAKE: begin
                if (cnt_reg == '0) begin
                    state_next = aotb_pkg::ST_ON;
                    cnt_next   = (TON_CYCLES > 1) ? aotb_pkg::CNT_W'(TON_CYCLES - 1'b1) : '0;
                end
            end
            default: begin
                state_next = aotb_pkg::ST_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg <= aotb_pkg::ST_IDLE;
            cnt_reg   <= '0;
        end else if (CE) begin
            if (!en_s) begin
                state_reg <= aotb_pkg::ST_IDLE;
                cnt_reg   <= '0;
            end else begin
                state_reg <= state_next;
                cnt_reg   <= cnt_next;
            end
        end
    end

    // Bias restore flag, set while enabled in every next state but ST_DCM
    always_ff @(posedge CLK) begin
        if (SRST) begin
            wake_bias_reg <= 1'b0;
        end else if (CE) begin
            wake_bias_reg <= en_s && (state_next != aotb_pkg::ST_DCM);
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    // drives from state
    always_ff @(posedge CLK) begin
        if (SRST) begin
            GATE <= '0;
        end else if (CE) begin
            GATE.high_side_gate_drive <= en_s && (state_next == aotb_pkg::ST_ON);
            GATE.low_side_gate_drive  <= en_s && (state_next == aotb_pkg::ST_OFF);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            STATUS        <= '0;
            BIAS_RESTORED <= 1'b0;
        end else if (CE) begin
            STATUS.low_power <= en_s && (state_next == aotb_pkg::ST_DCM);
            STATUS.ss_done   <= ss_done;
            STATUS.ref_code  <= ref_code;
            BIAS_RESTORED    <= wake_bias_reg;
        end
    end
endmodule : aotb_ctrl

/* File: design/aotb_pkg.sv */
package aotb_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 10;
    localparam int MIN_OFF_NS       = 200;
    localparam int DEAD_TIME_NS     = 30;
    localparam int SS_RAMP_US       = 6000;
    localparam int MIN_OFF_CYC      = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_CYC         = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Reference steps: 0.8 V / 9.7 mV rounds up to 83 steps
    localparam int REF_FULL_MV10    = 8000;
    localparam int REF_STEP_MV10    = 97;
    localparam int SS_STEPS         = (REF_FULL_MV10 + REF_STEP_MV10 - 1) / REF_STEP_MV10;
    localparam int SS_STEP_CYC      = (SS_RAMP_US * 1000 / CLK_PERIOD_NS) / SS_STEPS;
    localparam int CODE_W           = 7;
    localparam int TON_W            = 16;
    localparam int CNT_W            = 16;
    localparam logic [CODE_W-1:0] REF_CODE_RST = 7'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b000_0001,
        ST_DEAD_H = 7'b000_0010,
        ST_ON     = 7'b000_0100,
        ST_DEAD_L = 7'b000_1000,
        ST_OFF    = 7'b001_0000,
        ST_DCM    = 7'b010_0000,
        ST_WAKE   = 7'b100_0000
    } aotb_state_t;

    typedef struct packed {
        logic high_side_gate_drive;
        logic low_side_gate_drive;
    } aotb_gate_t;

    typedef struct packed {
        logic             low_power;
        logic             ss_done;
        logic [CODE_W-1:0] ref_code;
    } aotb_status_t;

endpackage : aotb_pkg

/* File: design/aotb_sync.sv */
`timescale 1ns/100ps
module aotb_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // Two-stage synchroniser, first stage read only by second
    always_ff @(posedge clk) begin
        if (ce) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : aotb_sync

/* File: design/aotb_softstart.sv */
`timescale 1ns/100ps
module aotb_softstart #(
    parameter int STEP_CYC = aotb_pkg::SS_STEP_CYC,
    parameter int STEPS    = aotb_pkg::SS_STEPS
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        ce,
    input  wire logic                        en,
    output logic [aotb_pkg::CODE_W-1:0]      ref_code,
    output logic                             done
);
    logic [aotb_pkg::CNT_W-1:0] tick_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            tick_reg <= '0;
            ref_code <= aotb_pkg::REF_CODE_RST;
            done     <= 1'b0;
        end else if (ce) begin
            if (!en) begin
                tick_reg <= '0;
                ref_code <= aotb_pkg::REF_CODE_RST;
                done     <= 1'b0;
            end else if (!done) begin
                if (tick_reg == aotb_pkg::CNT_W'(STEP_CYC - 1)) begin
                    tick_reg <= '0;
                    ref_code <= ref_code + 1'b1;
                    done     <= (ref_code == aotb_pkg::CODE_W'(STEPS - 1));
                end else begin
                    tick_reg <= tick_reg + 1'b1;
                end
            end
        end
    end
endmodule : aotb_softstart

/* File: bench/aotb_checker.sv */
`timescale 1ns/100ps
module aotb_checker #(
    parameter int MIN_OFF_CYC = 20,
    parameter int DEAD_CYC    = 3
) (
    input wire logic                   CLK,
    input wire logic                   SRST,
    input wire logic                   ENABLE,
    input wire logic                   FB_BELOW_REF,
    input wire aotb_pkg::aotb_gate_t   GATE,
    input wire logic                   BIAS_RESTORED,
    input wire aotb_pkg::aotb_status_t STATUS
);
    // ****************
    // Drive timing
    // ****************
    wire       h  = GATE.high_side_gate_drive;
    wire       l  = GATE.low_side_gate_drive;
    wire       lp = STATUS.low_power;
    logic [7:0] gap;
    // Cycles since high side last on
    always_ff @(posedge CLK) begin
        gap <= (SRST || h) ? 8'h00 : ((gap == 8'hff) ? gap : gap + 8'h01);
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    property p_excl; !(h && l); endproperty
    a_excl: assert property (p_excl) else $error("both drives high");
    property p_dead; $fell(l) |-> (!h)[*3]; endproperty
    a_dead: assert property (p_dead) else $error("dead time short");
    property p_minoff; $rose(h) && $past(gap) != 8'h00 |-> gap >= MIN_OFF_CYC + DEAD_CYC; endproperty
    a_minoff: assert property (p_minoff) else $error("off interval short");
    property p_held; $rose(l) && FB_BELOW_REF |-> l[*8] ##1 l[*8] ##1 l ##1 !l; endproperty
    a_held: assert property (p_held) else $error("held trigger off length");
    property p_dcm; lp |-> !h && !l; endproperty
    a_dcm: assert property (p_dcm) else $error("drive in low power");
    property p_bias; $rose(lp) |=> !BIAS_RESTORED; endproperty
    a_bias: assert property (p_bias) else $error("bias not reduced");
    property p_wake; $fell(lp) |-> !h ##[1:4] h; endproperty
    a_wake: assert property (p_wake) else $error("wake order");
    property p_done; STATUS.ss_done |-> STATUS.ref_code == 7'h53; endproperty
    a_done: assert property (p_done) else $error("done before full scale");
    property p_off; (!ENABLE)[*4] |=> !h && !l && STATUS.ref_code == 7'h00; endproperty
    a_off: assert property (p_off) else $error("disable not honoured");
endmodule : aotb_checker
bind aotb_ctrl aotb_checker #(.MIN_OFF_CYC(MIN_OFF_CYC), .DEAD_CYC(DEAD_CYC)) aotb_checker_i (
    .CLK(CLK), .SRST(SRST), .ENABLE(ENABLE), .FB_BELOW_REF(FB_BELOW_REF),
    .GATE(GATE), .BIAS_RESTORED(BIAS_RESTORED), .STATUS(STATUS));

/* File: bench/aotb_fet_model.sv */
`timescale 1ns/100ps
module aotb_fet_model #(
    parameter int ZC_DLY = 25
) (
    input  wire logic            clk,
    input  wire logic            light,
    input  wire aotb_pkg::aotb_gate_t gate,
    output logic                 zc
);
    logic [7:0] lcnt = 8'h00;
    // Low-side conduction time
    always_ff @(posedge clk) begin
        lcnt <= gate.low_side_gate_drive ? lcnt + 8'h01 : 8'h00;
    end
    // Current reverses late in conduction when lightly loaded
    assign zc = light && gate.low_side_gate_drive && (lcnt >= ZC_DLY);
endmodule : aotb_fet_model

/* File: bench/aotb_ctrl_bench.sv */
`timescale 1ns/100ps
module aotb_ctrl_bench;
    logic clk = 1'b0, srst = 1'b1, en = 1'b0, fb = 1'b0, light = 1'b0, ce = 1'b1, zc, bias;
    aotb_pkg::aotb_status_t st_c;
    logic [15:0] ton = 16'h000a;
    aotb_pkg::aotb_gate_t   gate;
    aotb_pkg::aotb_status_t st;
    int fail_count = 0, check_count = 0, cyc = 0;
    // ****************
    // Clock and parts
    // ****************
    always #5 clk = ~clk;
    aotb_ctrl #(.SS_STEP_CYC(4)) aotb_ctrl_i (.CLK(clk), .SRST(srst), .CE(ce), .ENABLE(en),
        .FB_BELOW_REF(fb), .ZERO_CROSS_DETECT(zc), .TON_CYCLES(ton), .GATE(gate),
        .BIAS_RESTORED(bias), .STATUS(st));
    // Continuous-only variant sharing the same stimulus
    aotb_ctrl #(.SS_STEP_CYC(4), .LIGHT_LOAD(1'b0)) aotb_ctrl_ccm_i (.CLK(clk), .SRST(srst), .CE(ce),
        .ENABLE(en), .FB_BELOW_REF(fb), .ZERO_CROSS_DETECT(zc), .TON_CYCLES(ton), .GATE(),
        .BIAS_RESTORED(), .STATUS(st_c));
    aotb_fet_model aotb_fet_model_i (.clk(clk), .light(light), .gate(gate), .zc(zc));
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    // Watchdog on run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results;
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask : chk
    // Count cycles until a drive reaches a level
    task automatic wait_lvl(input bit hs, input logic v, output int n);
        n = 0;
        while (((hs ? gate.high_side_gate_drive : gate.low_side_gate_drive) !== v) && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_lvl
    task automatic t_ss;
        int n;
        n = 0;
        chk("ref_rst", 16'h0000, st.ref_code);
        en = 1'b1;
        while (st.ss_done !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk("ref_full", 16'h0053, st.ref_code);
        chk("ss_len", 16'h0001, n >= 332);
    endtask : t_ss
    task automatic t_on(input logic [15:0] t, input logic [15:0] w);
        int n;
        ton = t;
        fb = 1'b1;
        wait_lvl(1, 1, n);
        fb = 1'b0;
        wait_lvl(1, 0, n);
        chk("on_len", w, n[15:0]);
        wait_lvl(0, 1, n);
        chk("dead_hl", 16'h0003, n[15:0]);
    endtask : t_on
    task automatic t_held;
        int n;
        ton = 16'h000a;
        fb = 1'b1;
        for (int i = 0; i < 2; i++) begin
            wait_lvl(0, 0, n);
            wait_lvl(0, 1, n);
            wait_lvl(0, 0, n);
            chk("min_off", 16'h0011, n[15:0]);
        end
        wait_lvl(1, 1, n);
        fb = 1'b0;
        wait_lvl(0, 1, n);
        repeat (40) @(negedge clk);
        chk("off_hold", 16'h0001, gate.low_side_gate_drive);
    endtask : t_held
    task automatic t_dcm;
        int n;
        n = 0;
        light = 1'b1;
        while (st.low_power !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("dcm_drv", 16'h0000, gate);
        chk("ccm_lp", 16'h0000, st_c.low_power);
        @(negedge clk);
        chk("bias_low", 16'h0000, bias);
        fb = 1'b1;
        wait_lvl(1, 1, n);
        chk("wake_lp", 16'h0000, st.low_power);
        chk("wake_bias", 16'h0001, bias);
        fb = 1'b0;
        light = 1'b0;
        wait_lvl(0, 1, n);
    endtask : t_dcm
    task automatic t_dis;
        en = 1'b0;
        repeat (3) @(negedge clk);
        fb = 1'b1;
        repeat (6) @(negedge clk);
        chk("dis_drv", 16'h0000, gate);
        chk("dis_ref", 16'h0000, st.ref_code);
        fb = 1'b0;
        en = 1'b1;
        repeat (20) @(negedge clk);
        chk("ramp_rst", 16'h0000, st.ss_done);
        chk("ramp_again", 16'h0004, st.ref_code);
    endtask : t_dis
    task automatic t_ce;
        aotb_pkg::aotb_gate_t g;
        logic [6:0]           r;
        g  = gate;
        r  = st.ref_code;
        ce = 1'b0;
        fb = 1'b1;
        repeat (10) @(negedge clk);
        chk("ce_gate", g, gate);
        chk("ce_ref", r, st.ref_code);
        fb = 1'b0;
        ce = 1'b1;
        repeat (4) @(negedge clk);
    endtask : t_ce
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        t_ss;
        t_on(16'h0000, 16'h0001);
        t_on(16'h0001, 16'h0001);
        t_on(16'h000c, 16'h000c);
        t_held;
        t_dcm;
        t_dis;
        t_ce;
        results;
    end
endmodule : aotb_ctrl_bench
